// ### src/refmon_pkg.sv
// constants, tables and types of the input reference qualifier
// assumes a 25 MHz system clock and an APB master for software access
// Overview of operation
// - activity monitored only for inputs above 1kHz
// - 3-bit activity band select, 1000 to 12ppm
// - activity alarm after out-of-band over 2.5ms
// - activity alarm routable to pin and alert
// - per-input timer starts on activity/loss alarm
// - disqualify only if alarm holds full period
// - enables choose which alarms drive disqualification
// - disqualify period select: 2.5s,1.25ms,25ms,50ms
// - requalify after alarms clear for full period
// - requalify period is 4,2,8,16 times disqualify
// - offset alarm raised beyond rejection limit
// - offset alarm clears only within acceptance limit
// - 3-bit offset limit field maps limit pairs
// - valid needs qualified input, no unmasked offset alarm, no gpio block
// - any gpio can disqualify chosen inputs
// - active input lost triggers switch to valid one
// - all inputs monitored always, active one included
// - gapped loss after 1,2,5 missed clocks; 00 off
package refmon_pkg;
  localparam int NREF  = 4;
  localparam int NDPLL = 2;
  localparam int NGPIO = 4;
  // timing
  localparam int CLK_NS       = 40;
  localparam int TICK_US      = 1250;
  localparam int TICK_CYC_DEF = TICK_US * 1000 / CLK_NS;
  localparam int ACT_MIN_HZ   = 1000;
  localparam logic [15:0] ACT_MIN_CNT = 16'(ACT_MIN_HZ * TICK_US / 1000000);
  localparam logic [1:0] ACT_FAIL_WIN = 2'h2;
  localparam int DISQ_US [4] = '{2500000, 1250, 25000, 50000};
  localparam logic [39:0] PPM_SCALE = 40'h0000989680;
  // ppm limits in tenths of a ppm
  localparam logic [7:0][13:0] ACT_PPM10 = {14'h0078, 14'h00B4, 14'h0208,
    14'h028A, 14'h033E, 14'h0514, 14'h0A28, 14'h2710};
  localparam logic [7:0][13:0] FRQ_ACC10 = {14'h03E8, 14'h0280, 14'h0208,
    14'h0190, 14'h016E, 14'h00F5, 14'h008A, 14'h005C};
  localparam logic [7:0][13:0] FRQ_REJ10 = {14'h0514, 14'h033E, 14'h02A3,
    14'h0208, 14'h01DB, 14'h0140, 14'h00B4, 14'h0078};
  localparam logic [3:0][2:0] QUAL_SHIFT = {3'h4, 3'h3, 3'h1, 3'h2};
  localparam logic [3:0][2:0] LOS_NEED   = {3'h5, 3'h2, 3'h1, 3'h0};
  // register byte offsets
  localparam logic [7:0] A_INT_STAT = 8'h00;
  localparam logic [7:0] A_INT_MASK = 8'h04;
  localparam logic [7:0] A_GPIO_MAP = 8'h08;
  localparam logic [7:0] A_ALLOW    = 8'h0C;
  localparam logic [7:0] A_ACTIVE   = 8'h10;
  localparam logic [7:0] A_LIVE     = 8'h14;
  localparam logic [3:0] A_CFG_HI   = 4'h2;
  localparam logic [3:0] A_NOM_HI   = 4'h3;
  // interrupt status bit positions
  localparam int I_ACT  = 0;
  localparam int I_LOS  = 4;
  localparam int I_FRQ  = 8;
  localparam int I_DISQ = 12;
  localparam int I_SW   = 16;
  localparam int IW     = 18;

  typedef enum logic [3:0] {
    Q_OK    = 4'b0001,
    Q_DWAIT = 4'b0010,
    Q_DISQ  = 4'b0100,
    Q_RWAIT = 4'b1000
  } qstate_t;

  typedef struct packed {
    logic       route_alert;
    logic       route_gpio;
    logic       en_frq;
    logic       en_los;
    logic       en_act;
    logic [1:0] requal_multiple_select;
    logic [1:0] disqual_period_select;
    logic [1:0] los_mode;
    logic [2:0] frq_lim;
    logic [2:0] act_lim;
  } ref_cfg_t;

  localparam ref_cfg_t CFG_RST = 17'h07000;

  typedef struct packed {
    logic [NREF-1:0]             rs0;
    logic [NREF-1:0]             rs1;
    logic [NREF-1:0]             rs2;
    logic [NGPIO-1:0]            gs0;
    logic [NGPIO-1:0]            gs1;
    logic [31:0]                 tick_cnt;
    logic [NREF-1:0][15:0]       edge_cnt;
    logic [NREF-1:0][15:0]       gap_cnt;
    logic [NREF-1:0][2:0]        miss;
    logic [NREF-1:0][1:0]        act_run;
    logic [NREF-1:0]             act;
    logic [NREF-1:0]             signal_loss_alarm;
    logic [NREF-1:0]             frq;
    qstate_t [NREF-1:0]          qst;
    logic [NREF-1:0][14:0]       qtmr;
    ref_cfg_t [NREF-1:0]         cfg;
    logic [NREF-1:0][31:0]       nom;
    logic [NGPIO-1:0][NREF-1:0]  gmap;
    logic [NDPLL-1:0][NREF-1:0]  allow;
    logic [NDPLL-1:0][1:0]       active;
    logic [NDPLL-1:0][NREF-1:0]  valid;
    logic [IW-1:0]               ist;
    logic [IW-1:0]               imask;
    logic [31:0]                 prdata;
    logic                        pslverr;
    logic [NREF-1:0]             act_pin;
    logic                        alert;
    logic                        irq;
  } mon_state_t;

  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  // true when offset d exceeds ppm10 tenths-of-ppm of nominal n
  function automatic logic exceed(input logic [15:0] d, input logic [15:0] n,
                                  input logic [13:0] ppm10);
    logic [39:0] lhs;
    logic [39:0] rhs;
    lhs    = 40'(d) * PPM_SCALE;
    rhs    = 40'(n) * 40'(ppm10);
    exceed = lhs > rhs;
  endfunction

  function automatic logic [14:0] disq_ticks(input logic [1:0] sel);
    disq_ticks = 15'(DISQ_US[sel] / TICK_US);
  endfunction

  function automatic logic [1:0] first_valid(input logic [NREF-1:0] v);
    first_valid = 2'h0;
    for (int k = NREF - 1; k >= 0; k--) begin
      if (v[k]) begin
        first_valid = 2'(k);
      end
    end
  endfunction
endpackage

// ### src/input_reference_qualifier.sv
// reference monitors, qualify/disqualify timers and validity per channel
// assumes ref_clk and gpio_in are asynchronous pins, apb on mclk
module input_reference_qualifier
  import refmon_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF
) (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // reference inputs and loss-indicator pins
  input  wire logic [NREF-1:0]        ref_clk,
  input  wire logic [NGPIO-1:0]       gpio_in,
  // alarms and channel status
  output logic      [NREF-1:0]        act_alarm_pin,
  output logic                        alert_out,
  output logic                        irq,
  output logic      [NDPLL-1:0][NREF-1:0] ref_valid,
  output logic      [NDPLL-1:0][1:0]  active_ref
);

  mon_state_t                 s;
  mon_state_t                 next_s;
  logic                       tick;
  logic [NREF-1:0]            edges;
  logic [NREF-1:0]            gblk;
  logic [NREF-1:0]            qual;
  logic [NREF-1:0]            blocked;
  logic [NREF-1:0]            disq_ev;
  logic [NDPLL-1:0]           sw_ev;
  logic [NDPLL-1:0][NREF-1:0] valid_c;
  logic [NREF-1:0]            rt_gpio;
  logic [NREF-1:0]            rt_alert;
  logic [IW-1:0]              ev;
  logic [15:0]                d;
  logic [15:0]                nomc;
  logic [15:0]                per;
  logic [14:0]                dlim;
  logic [14:0]                qlim;
  logic [2:0]                 miss_n;
  logic                       bad;
  logic                       contrib;
  logic                       setup;
  logic                       wr;
  logic [1:0]                 idx;
  ref_cfg_t                   c;

  always_comb begin
    next_s   = s;
    tick     = (s.tick_cnt == 32'(TICK_CYC - 1));
    edges    = s.rs1 & ~s.rs2;
    gblk     = '0;
    qual     = '0;
    blocked  = '0;
    disq_ev  = '0;
    sw_ev    = '0;
    valid_c  = '0;
    rt_gpio  = '0;
    rt_alert = '0;
    d        = '0;
    nomc     = '0;
    per      = '0;
    dlim     = '0;
    qlim     = '0;
    miss_n   = '0;
    bad      = 1'b0;
    contrib  = 1'b0;
    c        = CFG_RST;
    setup    = psel & ~penable;
    wr       = psel & penable & pwrite & ~s.pslverr;
    idx      = paddr[3:2];

    // pin synchronisers
    next_s.rs0 = ref_clk;
    next_s.rs1 = s.rs0;
    next_s.rs2 = s.rs1;
    next_s.gs0 = gpio_in;
    next_s.gs1 = s.gs0;

    // 1.25ms measurement and timer tick
    next_s.tick_cnt = tick ? 32'h0 : s.tick_cnt + 32'h1;

    // gpio disqualifiers
    for (int g = 0; g < NGPIO; g++) begin
      if (s.gs1[g]) begin
        gblk = gblk | s.gmap[g];
      end
    end

    // every input is watched whether in use or not
    for (int i = 0; i < NREF; i++) begin
      c           = s.cfg[i];
      nomc        = s.nom[i][15:0];
      per         = s.nom[i][31:16];
      rt_gpio[i]  = c.route_gpio;
      rt_alert[i] = c.route_alert;

      // activity and frequency offset, evaluated once per window
      if (tick) begin
        d   = absdiff(s.edge_cnt[i], nomc);
        bad = (nomc > ACT_MIN_CNT) && exceed(d, nomc, ACT_PPM10[c.act_lim]);
        if (!bad) begin
          next_s.act_run[i] = 2'h0;
        end else if (s.act_run[i] != ACT_FAIL_WIN) begin
          next_s.act_run[i] = s.act_run[i] + 2'h1;
        end
        next_s.act[i] = bad && ((s.act_run[i] + 2'h1) >= ACT_FAIL_WIN);
        if (nomc == 16'h0000) begin
          next_s.frq[i] = 1'b0;
        end else if (!s.frq[i]) begin
          next_s.frq[i] = exceed(d, nomc, FRQ_REJ10[c.frq_lim]);
        end else begin
          next_s.frq[i] = exceed(d, nomc, FRQ_ACC10[c.frq_lim]);
        end
        next_s.edge_cnt[i] = {15'h0000, edges[i]};
      end else begin
        next_s.edge_cnt[i] = s.edge_cnt[i] + {15'h0000, edges[i]};
      end

      // gapped clock loss
      if (edges[i] || c.los_mode == 2'h0) begin
        next_s.gap_cnt[i]           = 16'h0000;
        next_s.miss[i]              = 3'h0;
        next_s.signal_loss_alarm[i] = 1'b0;
      end else if (per != 16'h0000 && s.gap_cnt[i] >= per - 16'h0001) begin
        miss_n                      = (s.miss[i] == 3'h7) ? s.miss[i] : s.miss[i] + 3'h1;
        next_s.gap_cnt[i]           = 16'h0000;
        next_s.miss[i]              = miss_n;
        next_s.signal_loss_alarm[i] = miss_n >= LOS_NEED[c.los_mode];
      end else begin
        next_s.gap_cnt[i] = s.gap_cnt[i] + 16'h0001;
      end

      // qualify / disqualify timer
      contrib = (s.act[i] & c.en_act) | (s.signal_loss_alarm[i] & c.en_los);
      dlim    = disq_ticks(c.disqual_period_select);
      qlim    = dlim << QUAL_SHIFT[c.requal_multiple_select];
      case (s.qst[i])
        Q_OK: begin
          if (contrib) begin
            next_s.qst[i]  = Q_DWAIT;
            next_s.qtmr[i] = 15'h0000;
          end
        end
        Q_DWAIT: begin
          if (!contrib) begin
            next_s.qst[i]  = Q_OK;
            next_s.qtmr[i] = 15'h0000;
          end else if (tick) begin
            if (s.qtmr[i] + 15'h0001 >= dlim) begin
              next_s.qst[i] = Q_DISQ;
              disq_ev[i]    = 1'b1;
            end else begin
              next_s.qtmr[i] = s.qtmr[i] + 15'h0001;
            end
          end
        end
        Q_DISQ: begin
          if (!contrib) begin
            next_s.qst[i]  = Q_RWAIT;
            next_s.qtmr[i] = 15'h0000;
          end
        end
        Q_RWAIT: begin
          if (contrib) begin
            next_s.qst[i] = Q_DISQ;
          end else if (tick) begin
            if (s.qtmr[i] + 15'h0001 >= qlim) begin
              next_s.qst[i]  = Q_OK;
              next_s.qtmr[i] = 15'h0000;
            end else begin
              next_s.qtmr[i] = s.qtmr[i] + 15'h0001;
            end
          end
        end
        default: begin
          next_s.qst[i]  = Q_OK;
          next_s.qtmr[i] = 15'h0000;
        end
      endcase
      qual[i]    = (s.qst[i] == Q_OK) || (s.qst[i] == Q_DWAIT);
      blocked[i] = (s.frq[i] & c.en_frq) | gblk[i];
    end

    // validity per channel and switchover
    for (int k = 0; k < NDPLL; k++) begin
      valid_c[k]      = s.allow[k] & qual & ~blocked;
      next_s.valid[k] = valid_c[k];
      if (!valid_c[k][s.active[k]] && (|valid_c[k])) begin
        next_s.active[k] = first_valid(valid_c[k]);
        sw_ev[k]         = 1'b1;
      end
    end

    ev = {sw_ev, disq_ev, next_s.frq & ~s.frq,
          next_s.signal_loss_alarm & ~s.signal_loss_alarm, next_s.act & ~s.act};

    // apb read data captured in the setup cycle
    if (setup) begin
      next_s.pslverr = 1'b0;
      next_s.prdata  = 32'h00000000;
      if (paddr[7:4] == A_CFG_HI) begin
        next_s.prdata = {15'h0000, s.cfg[idx]};
      end else if (paddr[7:4] == A_NOM_HI) begin
        next_s.prdata = s.nom[idx];
      end else begin
        case (paddr)
          A_INT_STAT: next_s.prdata = {14'h0000, s.ist};
          A_INT_MASK: next_s.prdata = {14'h0000, s.imask};
          A_GPIO_MAP: next_s.prdata = {16'h0000, s.gmap};
          A_ALLOW:    next_s.prdata = {24'h000000, s.allow};
          A_ACTIVE:   next_s.prdata = {26'h0000000, s.active[1], 2'h0, s.active[0]};
          A_LIVE:     next_s.prdata = {4'h0, s.gs1, s.valid, qual, s.frq,
                                       s.signal_loss_alarm, s.act};
          default:    next_s.pslverr = 1'b1;
        endcase
      end
    end

    // apb writes at the access edge
    if (wr) begin
      if (paddr[7:4] == A_CFG_HI) begin
        next_s.cfg[idx] = ref_cfg_t'(pwdata[16:0]);
      end else if (paddr[7:4] == A_NOM_HI) begin
        next_s.nom[idx] = pwdata;
      end else begin
        case (paddr)
          A_INT_STAT: next_s.ist = s.ist & ~pwdata[IW-1:0];
          A_INT_MASK: next_s.imask = pwdata[IW-1:0];
          A_GPIO_MAP: next_s.gmap = pwdata[15:0];
          A_ALLOW:    next_s.allow = pwdata[7:0];
          A_ACTIVE: begin
            next_s.active[0] = pwdata[1:0];
            next_s.active[1] = pwdata[5:4];
          end
          default: ;
        endcase
      end
    end
    // a new event wins over a same-cycle clear
    next_s.ist = next_s.ist | ev;

    // alarm routing and interrupt
    next_s.act_pin = next_s.act & rt_gpio;
    next_s.alert   = |(next_s.act & rt_alert);
    next_s.irq     = |(next_s.ist & next_s.imask);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s     <= '0;
      s.qst <= {NREF{Q_OK}};
      s.cfg <= {NREF{CFG_RST}};
    end else begin
      s <= next_s;
    end
  end

  assign pready        = 1'b1;
  assign prdata        = s.prdata;
  assign pslverr       = s.pslverr;
  assign act_alarm_pin = s.act_pin;
  assign alert_out     = s.alert;
  assign irq           = s.irq;
  assign ref_valid     = s.valid;
  assign active_ref    = s.active;

endmodule // input_reference_qualifier

// ### verification/refclk_source_model.sv
// reference clock sources and loss-indicator pins for the qualifier
// assumes run and loss_req come from the bench; stopped clocks rest low
module refclk_source_model
  import refmon_pkg::*;
#(
  parameter int HALF_NS = 200
) (
  // control
  input  wire logic [NREF-1:0]  run,
  input  wire logic [NGPIO-1:0] loss_req,
  // pins
  output logic      [NREF-1:0]  ref_clk,
  output logic      [NGPIO-1:0] gpio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // external loss source drives the pin high
  assign gpio_in = loss_req;
  // 2.5 MHz sources, well above the activity floor
  for (genvar i = 0; i < NREF; i++) begin : g_src
    initial begin
      ref_clk[i] = 1'b0;
      #(7 + 3 * i);
      forever begin
        #HALF_NS;
        ref_clk[i] = run[i] ? ~ref_clk[i] : 1'b0;
      end
    end
  end
endmodule // refclk_source_model

// ### verification/input_reference_qualifier_properties.sv
// concurrent checks on the ports of the input reference qualifier
// assumes it is bound to the top module, one clock domain
module input_reference_qualifier_properties
  import refmon_pkg::*;
#(
  parameter int TICK_CYC = 50
) (
  // clock and reset
  input wire logic                       mclk,
  input wire logic                       rst_n,
  // apb
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [7:0]                 paddr,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // status
  input wire logic [NREF-1:0]            act_alarm_pin,
  input wire logic                       irq,
  input wire logic [NDPLL-1:0][NREF-1:0] ref_valid,
  input wire logic [NDPLL-1:0][1:0]      active_ref
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [15:0] cyc;
  logic        unm;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) cyc <= '0;
    else if (cyc != 16'hFFFF) cyc <= cyc + 16'h1;
  end
  assign unm = (paddr[7:3] == 5'h03) || (paddr[7:6] != 2'h0) ||
               (paddr[7:5] == 3'h0 && paddr[1:0] != 2'h0);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_wr;
    psel && penable && pwrite;
  endsequence
  a_ready_access: assert property (s_access |-> pready)
    else $error("pready low in access");
  a_unmapped_err: assert property (s_access |-> pslverr == unm)
    else $error("pslverr does not match decode");
  a_err_reads_zero: assert property (s_access and !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_read_holds: assert property (!psel && $past(!psel) |-> $stable(prdata))
    else $error("prdata moved while idle");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(psel && penable && pwrite) ||
    $past(psel && penable && pwrite, 2)) else $error("irq fell without a write");
  a_reset_quiet: assert property ($rose(rst_n) |-> ref_valid == '0 && !irq)
    else $error("outputs active after reset");
  a_switch_on_loss: assert property (!ref_valid[0][active_ref[0]] && ref_valid[0] != '0 &&
    !(psel && penable && pwrite) |-> ##[1:3] ref_valid[0][active_ref[0]])
    else $error("no switchover");
  a_alarm_not_early: assert property ($rose(|act_alarm_pin) |-> cyc >= 16'(2 * TICK_CYC - 2))
    else $error("activity alarm too early");
endmodule // input_reference_qualifier_properties

// ### verification/test_input_reference_qualifier.sv
// self-checking bench of the input reference qualifier
// assumes refmon_pkg, the design and the source model are compiled first
module test_input_reference_qualifier
  import refmon_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 50;
  logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, alert_out, irq;
  logic [NREF-1:0] ref_clk, act_alarm_pin, run = 4'hF;
  logic [NGPIO-1:0] gpio_in, loss_req = 4'h0;
  logic [NDPLL-1:0][NREF-1:0] ref_valid;
  logic [NDPLL-1:0][1:0] active_ref;
  int err_total = 0, total_checks = 0, n;
  logic [31:0] rv;
  logic re;
  input_reference_qualifier #(.TICK_CYC(TC)) i_input_reference_qualifier (.mclk(mclk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_clk(ref_clk),
    .gpio_in(gpio_in), .act_alarm_pin(act_alarm_pin), .alert_out(alert_out), .irq(irq),
    .ref_valid(ref_valid), .active_ref(active_ref));
  refclk_source_model i_refclk_source_model (.run(run), .loss_req(loss_req),
    .ref_clk(ref_clk), .gpio_in(gpio_in));
  initial begin
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    total_checks++;
    if (g !== x) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rv = prdata; re = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk(rv, x, "read data");
    chk({31'h0, re}, {31'h0, xe}, "slave error");
  endtask
  task automatic t_regs;
    rd(8'h24, 32'h00007000, 1'b0);
    rd(8'h18, 32'h0, 1'b1);
    apb(1'b1, A_ALLOW, 32'h33);
    rd(A_ALLOW, 32'h33, 1'b0);
    rd(A_INT_MASK, 32'h0, 1'b0);
    repeat (3) @(posedge mclk);
    chk(ref_valid, 8'h33, "valid after allow");
    $display("test regs done");
  endtask
  task automatic t_activity;
    apb(1'b1, 8'h30, 32'h00100005);
    apb(1'b1, 8'h20, 32'h0001B500);
    apb(1'b1, A_INT_MASK, 32'h00011);
    repeat (4 * TC) @(posedge mclk);
    chk({31'h0, ref_valid[0][0]}, 1, "input 0 valid");
    run[0] <= 1'b0;
    for (n = 0; n < 400 && act_alarm_pin[0] !== 1'b1; n++) @(posedge mclk);
    chk(32'(n >= TC && n < 400), 1, "activity alarm delay");
    chk({31'h0, alert_out}, 1, "alert");
    for (n = 0; n < 200 && ref_valid[0][0] !== 1'b0; n++) @(posedge mclk);
    chk(32'(n < 200), 1, "disqualified");
    repeat (5) @(posedge mclk);
    chk(active_ref, 4'h5, "switchover");
    chk({31'h0, irq}, 1, "irq raised");
    apb(1'b0, A_INT_STAT, 32'h0);
    chk(rv & 32'h31001, 32'h31001, "status bits");
    apb(1'b1, A_INT_STAT, 32'h3FFFF);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 0, "irq cleared");
    run[0] <= 1'b1;
    for (n = 0; n < 800 && ref_valid[0][0] !== 1'b1; n++) @(posedge mclk);
    chk(32'(n >= 2 * TC && n < 800), 1, "requalified");
    chk(active_ref, 4'h5, "no revert");
    $display("test activity done");
  endtask
  task automatic t_gpio;
    apb(1'b1, A_GPIO_MAP, 32'h200);
    loss_req[2] <= 1'b1;
    for (n = 0; n < 20 && ref_valid[0][1] !== 1'b0; n++) @(posedge mclk);
    chk(32'(n < 20), 1, "gpio blocks input");
    repeat (5) @(posedge mclk);
    chk(active_ref, 4'h0, "switch to lowest");
    loss_req[2] <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(ref_valid, 8'h33, "gpio released");
    apb(1'b1, A_ACTIVE, 32'h22);
    repeat (2) @(posedge mclk);
    chk(active_ref, 4'h0, "invalid active replaced");
    rd(A_ACTIVE, 32'h0, 1'b0);
    $display("test gpio done");
  endtask
  task automatic t_loss;
    apb(1'b1, 8'h20, 32'h000032C0);
    run[0] <= 1'b0;
    repeat (40) @(posedge mclk);
    apb(1'b0, A_LIVE, 32'h0);
    chk({31'h0, rv[4]}, 0, "no loss before five misses");
    repeat (60) @(posedge mclk);
    apb(1'b0, A_LIVE, 32'h0);
    chk({31'h0, rv[4]}, 1, "loss after five misses");
    repeat (400) @(posedge mclk);
    run[0] <= 1'b1;
    repeat (20) @(posedge mclk);
    apb(1'b0, A_LIVE, 32'h0);
    chk({31'h0, rv[4]}, 0, "loss cleared by edge");
    repeat (200) @(posedge mclk);
    apb(1'b1, 8'h20, 32'h00003240);
    run[0] <= 1'b0;
    repeat (30) @(posedge mclk);
    apb(1'b0, A_LIVE, 32'h0);
    chk({31'h0, rv[4]}, 1, "loss after one miss");
    repeat (660) @(posedge mclk);
    chk({31'h0, ref_valid[0][0]}, 1, "timer restarted");
    run[0] <= 1'b1;
    repeat (120) @(posedge mclk);
    $display("test loss done");
  endtask
  task automatic t_freq;
    apb(1'b1, 8'h20, 32'h00006238);
    apb(1'b1, 8'h30, 32'h00100006);
    for (n = 0; n < 80 && ref_valid[0][0] !== 1'b0; n++) @(posedge mclk);
    chk(32'(n < 80), 1, "offset alarm blocks input");
    apb(1'b0, A_LIVE, 32'h0);
    chk(rv & 32'h1100, 32'h1100, "offset alarm, still qualified");
    apb(1'b1, 8'h30, 32'h00100005);
    for (n = 0; n < 80 && ref_valid[0][0] !== 1'b1; n++) @(posedge mclk);
    chk(32'(n < 80), 1, "offset alarm cleared");
    $display("test freq done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_activity();
    t_gpio();
    t_loss();
    t_freq();
    summarize();
  end
  initial begin
    #(40 * 20000);
    err_total++;
    summarize();
  end
endmodule // test_input_reference_qualifier
bind input_reference_qualifier input_reference_qualifier_properties #(.TICK_CYC(TICK_CYC))
  i_props (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .act_alarm_pin(act_alarm_pin), .irq(irq), .ref_valid(ref_valid), .active_ref(active_ref));
